// file: src/rtc_calendar_alarm_sqw.sv
/*
 Calendar clock top: BCD time and date, one alarm with interrupt pin,
 oscillator stall flag and square-wave pin, reached over a two-wire
 serial target. Pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Two-digit years divisible by four are leap
// - Time and date BCD registers at 02-08
// - Oscillator stall sets fail flag, seconds bit 7
// - Word address is a full byte
// - No answer to word addresses above 0f
// - Alarm field compared only while enable bit clear
// - Alarm match raises interrupt to host
// - Any combination of one or more alarm fields may match
// - Alarm flag lives in bit 3, register 01
// - Alarm interrupt enable bit 1, resets off
// - Square-wave enable is bit 7 of 0d
// - Four square-wave rates chosen by two bits
// - Weekday bits 2-0 of 06, counts 0-6
// - Select codes 00 fastest through 11 slowest
// - Enable clear releases pin; default enabled
// - Writing 0 clears alarm flag, 1 keeps
module rtc_calendar_alarm_sqw import rtc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h51,
  parameter int OSC_STALL_CYC = OSC_STALL_CYC_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Oscillator
  input wire logic osc_clk_in,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt pin, open drain
  output logic irq_n_out,
  output logic irq_oe,
  // Square-wave pin, open drain
  output logic square_wave_out,
  output logic square_wave_oe
);
  localparam int STALL_W = $clog2(OSC_STALL_CYC + 1);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n_s;
  logic [2:0] pin_meta_q, pin_sync_q;
  logic osc_s, scl_s, sda_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_s = rst_sync_q[1];

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_meta_q <= 3'b111;
      pin_sync_q <= 3'b111;
    end else begin
      pin_meta_q <= {osc_clk_in, scl_in, sda_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign osc_s = pin_sync_q[2];
  assign scl_s = pin_sync_q[1];
  assign sda_s = pin_sync_q[0];

  // ==========================================================
  // Serial target
  logic wr_stb;
  logic [3:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, wr_sel, rd_sel;

  i2c_target_engine #(.DEV_ADDR(DEV_ADDR)) u_target (
    .clk(mclk),
    .rst_n(rst_n_s),
    .scl(scl_s),
    .sda(sda_s),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign wr_sel = {4'h0, wr_addr};
  assign rd_sel = {4'h0, rd_addr};

  // ==========================================================
  // Oscillator divider and stall watch
  logic osc_prev_q, osc_rise, sec_tick, stall_hit, osc_fail_flag_q;
  logic [PRESC_W-1:0] presc_q;
  logic [STALL_W-1:0] stall_q;
  logic [TIME_FIELDS-1:0] wr_hit, carry, wrap;

  // Resets to the synchroniser's level, so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) osc_prev_q <= 1'b1;
    else osc_prev_q <= osc_s;
  end
  assign osc_rise = osc_s & ~osc_prev_q;
  assign sec_tick = osc_rise & (&presc_q);

  // Writing seconds restarts the second so the new value lasts a full second
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) presc_q <= '0;
    else if (wr_hit[IX_SEC]) presc_q <= '0;
    else if (osc_rise) presc_q <= presc_q + 1'b1;
  end

  // No oscillator edge for the stall time means the crystal stopped
  assign stall_hit = (stall_q == STALL_W'(OSC_STALL_CYC - 1));
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) stall_q <= '0;
    else if (osc_s != osc_prev_q) stall_q <= '0;
    else if (!stall_hit) stall_q <= stall_q + 1'b1;
  end

  // Set wins over a host clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) osc_fail_flag_q <= FAIL_RST;
    else if (stall_hit) osc_fail_flag_q <= 1'b1;
    else if (wr_hit[IX_SEC] && !wr_data[FAIL_BIT]) osc_fail_flag_q <= 1'b0;
  end

  // ==========================================================
  // Calendar counters
  logic [7:0] time_q [TIME_FIELDS];
  logic [7:0] month_last;
  logic leap;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == BCD_NINE) bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    else bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction

  // Good until 2100, which this rule wrongly calls leap
  assign leap = time_q[IX_YEAR][4] ?
    (time_q[IX_YEAR][3:0] == 4'h2 || time_q[IX_YEAR][3:0] == 4'h6) :
    (time_q[IX_YEAR][3:0] == 4'h0 || time_q[IX_YEAR][3:0] == 4'h4 ||
     time_q[IX_YEAR][3:0] == 4'h8);

  always_comb begin
    case (time_q[IX_MONTH])
      MONTH_FEB: month_last = leap ? DAYS_29 : DAYS_28;
      MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: month_last = DAYS_30;
      default: month_last = DAYS_31;
    endcase
  end

  // Weekday rolls with the day of month, in parallel
  assign carry[IX_SEC] = sec_tick;
  assign carry[IX_MIN] = carry[IX_SEC] & wrap[IX_SEC];
  assign carry[IX_HOUR] = carry[IX_MIN] & wrap[IX_MIN];
  assign carry[IX_DAY] = carry[IX_HOUR] & wrap[IX_HOUR];
  assign carry[IX_WDAY] = carry[IX_HOUR] & wrap[IX_HOUR];
  assign carry[IX_MONTH] = carry[IX_DAY] & wrap[IX_DAY];
  assign carry[IX_YEAR] = carry[IX_MONTH] & wrap[IX_MONTH];

  // A host write beats a tick in the same cycle
  for (genvar i = 0; i < TIME_FIELDS; i++) begin : g_time
    assign wr_hit[i] = wr_stb && (wr_sel == 8'(ADDR_SECONDS + i));
    assign wrap[i] = (time_q[i] == ((i == IX_DAY) ? month_last : TIME_LIMIT[i]));
    always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) time_q[i] <= TIME_START[i];
      else if (wr_hit[i]) time_q[i] <= wr_data & TIME_MASK[i];
      else if (carry[i]) time_q[i] <= wrap[i] ? TIME_START[i] : bcd_inc(time_q[i]);
    end
  end

  // ==========================================================
  // Alarm compare
  logic [7:0] alarm_q [ALARM_FIELDS];
  logic [ALARM_FIELDS-1:0] field_hit, field_used;
  logic alarm_match, match_q, alarm_event;

  for (genvar k = 0; k < ALARM_FIELDS; k++) begin : g_alarm
    always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) alarm_q[k] <= ALARM_RST;
      else if (wr_stb && wr_sel == 8'(ADDR_ALARM_MIN + k)) alarm_q[k] <= wr_data & ALARM_MASK[k];
    end
    // Each field votes on its own; a disabled field always agrees
    assign field_used[k] = ~alarm_q[k][FIELD_OFF_BIT];
    assign field_hit[k] = alarm_q[k][FIELD_OFF_BIT] |
      (alarm_q[k][6:0] == time_q[ALARM_SRC[k]][6:0]);
  end

  // At least one field must be enabled, else the alarm never fires
  assign alarm_match = (&field_hit) & (|field_used);
  assign alarm_event = alarm_match & ~match_q;
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) match_q <= 1'b0;
    else match_q <= alarm_match;
  end

  // ==========================================================
  // Alarm control and interrupt pin
  logic ctrl_wr, alarm_flag_q, alarm_irq_enable_q, irq_want, irq_oe_q;

  assign ctrl_wr = wr_stb && (wr_sel == ADDR_ALARM_CTRL);

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) alarm_flag_q <= 1'b0;
    else if (alarm_event) alarm_flag_q <= 1'b1;
    else if (ctrl_wr && !wr_data[FLAG_BIT]) alarm_flag_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) alarm_irq_enable_q <= 1'b0;
    else if (ctrl_wr) alarm_irq_enable_q <= wr_data[IRQ_EN_BIT];
  end

  assign irq_want = alarm_flag_q & alarm_irq_enable_q;
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) irq_oe_q <= 1'b0;
    else irq_oe_q <= irq_want;
  end
  assign irq_oe = irq_oe_q;
  assign irq_n_out = 1'b0;

  // ==========================================================
  // Square-wave output
  logic square_wave_enable_q, wave, wave_oe_q;
  logic [1:0] fsel_q;

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      square_wave_enable_q <= WAVE_EN_RST;
      fsel_q <= FSEL_32K;
    end else if (wr_stb && wr_sel == ADDR_WAVE_CTRL) begin
      square_wave_enable_q <= wr_data[WAVE_EN_BIT];
      fsel_q <= wr_data[FSEL_MSB:FSEL_LSB];
    end
  end

  // Taps halve the rate per prescaler bit below the oscillator
  always_comb begin
    case (fsel_q)
      FSEL_32K: wave = osc_s;
      FSEL_1K: wave = presc_q[TAP_1K];
      FSEL_32HZ: wave = presc_q[TAP_32HZ];
      FSEL_1HZ: wave = presc_q[PRESC_W-1];
      default: wave = osc_s;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) wave_oe_q <= 1'b0;
    else wave_oe_q <= square_wave_enable_q & ~wave;
  end
  assign square_wave_oe = wave_oe_q;
  assign square_wave_out = 1'b0;

  // ==========================================================
  // Register read mux
  always_comb begin
    rd_data = 8'h00;
    case (rd_sel)
      ADDR_ALARM_CTRL: begin
        rd_data[FLAG_BIT] = alarm_flag_q;
        rd_data[IRQ_EN_BIT] = alarm_irq_enable_q;
      end
      ADDR_SECONDS: begin
        rd_data = time_q[IX_SEC];
        rd_data[FAIL_BIT] = osc_fail_flag_q;
      end
      ADDR_MINUTES: rd_data = time_q[IX_MIN];
      ADDR_HOURS: rd_data = time_q[IX_HOUR];
      ADDR_DAY: rd_data = time_q[IX_DAY];
      ADDR_WEEKDAY: rd_data = time_q[IX_WDAY];
      ADDR_MONTH: rd_data = time_q[IX_MONTH];
      ADDR_YEAR: rd_data = time_q[IX_YEAR];
      ADDR_ALARM_MIN: rd_data = alarm_q[0];
      ADDR_ALARM_HOUR: rd_data = alarm_q[1];
      ADDR_ALARM_DAY: rd_data = alarm_q[2];
      ADDR_ALARM_WDAY: rd_data = alarm_q[3];
      ADDR_WAVE_CTRL: begin
        rd_data[WAVE_EN_BIT] = square_wave_enable_q;
        rd_data[FSEL_MSB:FSEL_LSB] = fsel_q;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Checks
  property p_flag_set;
    @(posedge mclk) disable iff (!rst_n_s)
    alarm_event |=> alarm_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set on match");

  property p_flag_clear;
    @(posedge mclk) disable iff (!rst_n_s)
    (ctrl_wr && !wr_data[FLAG_BIT] && !alarm_event) |=> !alarm_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("alarm flag not cleared");

  property p_flag_keep;
    @(posedge mclk) disable iff (!rst_n_s)
    (ctrl_wr && wr_data[FLAG_BIT] && alarm_flag_q) |=> alarm_flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("alarm flag lost on one write");

  property p_irq_follow;
    @(posedge mclk) disable iff (!rst_n_s)
    ##1 (irq_oe == $past(irq_want));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt pin wrong");

  // A host clear in the stall cycle must lose to the set
  property p_fail_stall;
    @(posedge mclk) disable iff (!rst_n_s)
    stall_hit |=> osc_fail_flag_q;
  endproperty
  a_fail_stall: assert property (p_fail_stall) else $error("stall did not set fail flag");

  property p_sec_wrap;
    @(posedge mclk) disable iff (!rst_n_s)
    (sec_tick && wrap[IX_SEC] && !wr_hit[IX_SEC] && !wr_hit[IX_MIN])
      |=> (time_q[IX_SEC] == TIME_START[IX_SEC]) && $changed(time_q[IX_MIN]);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not carry");

  property p_leap_day;
    @(posedge mclk) disable iff (!rst_n_s)
    (carry[IX_DAY] && leap && time_q[IX_MONTH] == MONTH_FEB &&
     time_q[IX_DAY] == DAYS_28 && !wr_hit[IX_DAY]) |=> time_q[IX_DAY] == DAYS_29;
  endproperty
  a_leap_day: assert property (p_leap_day) else $error("leap day skipped");

  property p_wday_wrap;
    @(posedge mclk) disable iff (!rst_n_s)
    (carry[IX_WDAY] && time_q[IX_WDAY] == TIME_LIMIT[IX_WDAY] && !wr_hit[IX_WDAY])
      |=> time_q[IX_WDAY] == TIME_START[IX_WDAY];
  endproperty
  a_wday_wrap: assert property (p_wday_wrap) else $error("weekday did not wrap");

  property p_wave_off;
    @(posedge mclk) disable iff (!rst_n_s)
    !square_wave_enable_q |=> !square_wave_oe;
  endproperty
  a_wave_off: assert property (p_wave_off) else $error("square wave driven while off");

  property p_wave_1hz;
    @(posedge mclk) disable iff (!rst_n_s)
    (square_wave_enable_q && fsel_q == FSEL_1HZ) |=>
      (square_wave_oe == !$past(presc_q[PRESC_W-1]));
  endproperty
  a_wave_1hz: assert property (p_wave_1hz) else $error("slow square wave wrong");

  property p_alarm_none;
    @(posedge mclk) disable iff (!rst_n_s)
    (field_used == '0 && !alarm_flag_q) |=> !alarm_flag_q;
  endproperty
  a_alarm_none: assert property (p_alarm_none) else $error("alarm with no field enabled");
endmodule
`default_nettype wire

// file: include/rtc_pkg.sv
/*
 Shared constants for the calendar clock: register map, field layouts,
 reset values, BCD limits, square-wave taps, timing and target states.
 Assumes the 250 MHz system clock and a 32.768 kHz oscillator input.
*/
package rtc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_ALARM_CTRL = 8'h01;
  localparam logic [7:0] ADDR_SECONDS = 8'h02;
  localparam logic [7:0] ADDR_MINUTES = 8'h03;
  localparam logic [7:0] ADDR_HOURS = 8'h04;
  localparam logic [7:0] ADDR_DAY = 8'h05;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h06;
  localparam logic [7:0] ADDR_MONTH = 8'h07;
  localparam logic [7:0] ADDR_YEAR = 8'h08;
  localparam logic [7:0] ADDR_ALARM_MIN = 8'h09;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0a;
  localparam logic [7:0] ADDR_ALARM_DAY = 8'h0b;
  localparam logic [7:0] ADDR_ALARM_WDAY = 8'h0c;
  localparam logic [7:0] ADDR_WAVE_CTRL = 8'h0d;
  localparam logic [7:0] ADDR_LAST = 8'h0f;

  // ==========================================================
  // Field positions and reset values
  localparam int FLAG_BIT = 3;
  localparam int IRQ_EN_BIT = 1;
  localparam int FAIL_BIT = 7;
  localparam int FIELD_OFF_BIT = 7;
  localparam int WAVE_EN_BIT = 7;
  localparam int FSEL_LSB = 0;
  localparam int FSEL_MSB = 1;
  localparam logic WAVE_EN_RST = 1'b1;
  localparam logic FAIL_RST = 1'b1;
  localparam logic [7:0] ALARM_RST = 8'h80;
  localparam logic [1:0] FSEL_32K = 2'b00;
  localparam logic [1:0] FSEL_1K = 2'b01;
  localparam logic [1:0] FSEL_32HZ = 2'b10;
  localparam logic [1:0] FSEL_1HZ = 2'b11;

  // ==========================================================
  // Time fields: index 0 seconds up to 6 years
  localparam int TIME_FIELDS = 7;
  localparam int IX_SEC = 0;
  localparam int IX_MIN = 1;
  localparam int IX_HOUR = 2;
  localparam int IX_DAY = 3;
  localparam int IX_WDAY = 4;
  localparam int IX_MONTH = 5;
  localparam int IX_YEAR = 6;
  localparam logic [6:0][7:0] TIME_MASK = {8'hff, 8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'h7f};
  localparam logic [6:0][7:0] TIME_LIMIT = {8'h99, 8'h12, 8'h06, 8'h31, 8'h23, 8'h59, 8'h59};
  localparam logic [6:0][7:0] TIME_START = {8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // Alarm fields: minute, hour, day, weekday and the time field each watches
  localparam int ALARM_FIELDS = 4;
  localparam logic [3:0][7:0] ALARM_MASK = {8'h87, 8'hbf, 8'hbf, 8'hff};
  localparam logic [3:0][2:0] ALARM_SRC = {3'd4, 3'd3, 3'd2, 3'd1};

  // ==========================================================
  // Oscillator division and timing
  localparam int PRESC_W = 15;
  localparam int TAP_1K = 4;
  localparam int TAP_32HZ = 9;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_STALL_US = 100;
  localparam int OSC_STALL_CYC_DEF = (OSC_STALL_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // Serial target
  localparam logic [3:0] BYTE_BITS = 4'd8;
  localparam logic [3:0] LAST_BIT = 4'd7;
  typedef enum logic [6:0] {
    T_IDLE = 7'b0000001,
    T_DEV  = 7'b0000010,
    T_REG  = 7'b0000100,
    T_WDAT = 7'b0001000,
    T_ACK  = 7'b0010000,
    T_RDAT = 7'b0100000,
    T_RACK = 7'b1000000
  } tgt_state_e;
endpackage

// file: src/i2c_target_engine.sv
/*
 Two-wire serial target: address match, register pointer, byte writes
 and sequential reads. Expects scl and sda already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_target_engine import rtc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h51
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // Register port
  output logic wr_stb,
  output logic [3:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [3:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic scl_q, sda_q, ack_q, sda_oe_q, wr_stb_q;
  logic [7:0] sh_q, wr_data_q;
  logic [3:0] cnt_q, ptr_q, wr_addr_q;
  tgt_state_e state_q, next_q;
  logic scl_rise, scl_fall, start_c, stop_c, load_c;

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c = scl & scl_q & ~sda_q & sda;
  assign load_c = ((state_q == T_ACK) && (next_q == T_RDAT)) || ((state_q == T_RACK) && ack_q);
  assign sda_oe = sda_oe_q;
  assign wr_stb = wr_stb_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign rd_addr = ptr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // ==========================================================
  // Byte engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= T_IDLE;
      next_q <= T_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 4'h0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_c) begin
        state_q <= T_DEV;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= T_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          T_DEV, T_REG, T_WDAT: begin
            sh_q <= {sh_q[6:0], sda};
            cnt_q <= cnt_q + 4'h1;
          end
          T_RACK: ack_q <= ~sda;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          T_DEV: if (cnt_q == BYTE_BITS) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              sda_oe_q <= 1'b1;
              state_q <= T_ACK;
              next_q <= sh_q[0] ? T_RDAT : T_REG;
            end else begin
              state_q <= T_IDLE;
            end
          end
          T_REG: if (cnt_q == BYTE_BITS) begin
            // Word address is a full byte; past the map the byte is refused
            if (sh_q <= ADDR_LAST) begin
              ptr_q <= sh_q[3:0];
              sda_oe_q <= 1'b1;
              state_q <= T_ACK;
              next_q <= T_WDAT;
            end else begin
              state_q <= T_IDLE;
            end
          end
          T_WDAT: if (cnt_q == BYTE_BITS) begin
            wr_stb_q <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= sh_q;
            ptr_q <= ptr_q + 4'h1;
            sda_oe_q <= 1'b1;
            state_q <= T_ACK;
            next_q <= T_WDAT;
          end
          T_RDAT: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == LAST_BIT) begin
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 4'h1;
              state_q <= T_RACK;
            end else begin
              sda_oe_q <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
          T_ACK, T_RACK: begin
            cnt_q <= 4'h0;
            if (load_c) begin
              sh_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
              state_q <= T_RDAT;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= (state_q == T_ACK) ? next_q : T_IDLE;
            end
          end
          default: state_q <= T_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/i2c_host_model.sv
/* Serial bus host model: bit, byte and register access tasks.
   Assumes a pull-up on the data line and the target's open-drain enable. */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h51
) (
  // Clock and bus
  input wire logic mclk,
  input wire logic dut_sda_oe,
  output logic scl,
  output logic sda
);
  logic pull = 1'b0;
  // Pull-up: a released line reads high
  assign sda = ~(pull | dut_sda_oe);
  initial scl = 1'b1;
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // ==========
  // Bit level; period scaled down from the host limit to keep runs short
  task automatic bit_io(input logic b, output logic r);
    w(4);
    pull = ~b;
    w(2);
    scl = 1'b1;
    w(6);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start_c();
    pull = 1'b1;
    w(6);
    scl = 1'b0;
  endtask
  task automatic rise_c(input logic p);
    w(4);
    pull = p;
    w(2);
    scl = 1'b1;
    w(6);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ai, ak);
  endtask
  // ==========
  // Register access; read ends with a host NACK
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic nk);
    logic [7:0] x;
    logic k0, k1, k2, k3;
    k2 = 1'b0;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, x, k0);
    xfer(a, 1'b1, x, k1);
    if (rd) begin
      rise_c(1'b0);
      start_c();
      xfer({DEV_ADDR, 1'b1}, 1'b1, x, k2);
    end
    xfer(rd ? 8'hff : d, 1'b1, q, k3);
    rise_c(1'b1);
    pull = 1'b0;
    w(6);
    nk = k0 | k1 | (rd ? k2 : k3);
  endtask
endmodule
`default_nettype wire

// file: sim/rtc_calendar_alarm_sqw_tb_top.sv
/* Bench for the calendar clock: register tests over the serial bus.
   Assumes the host model and a fast stand-in oscillator. */
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_sqw_tb_top import rtc_pkg::*; ;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  logic run = 1'b1;
  logic scl, sda, sda_oe, irq_oe, wave_oe, nk;
  logic [2:0] lows;
  logic [7:0] q;
  int num_errors = 0;
  int check_count = 0;
  int k;
  logic [7:0] tv [7] = '{8'h30, 8'h05, 8'h23, 8'h28, 8'h06, 8'h02, 8'h96};
  int lo [4] = '{50, 2, 0, 0};
  int hi [4] = '{700, 8, 1, 1};
  always #2 mclk = ~mclk;
  always #20 if (run) osc = ~osc;
  rtc_calendar_alarm_sqw #(.DEV_ADDR(7'h51), .OSC_STALL_CYC(64)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .osc_clk_in(osc), .scl_in(scl), .sda_in(sda),
    .sda_out(lows[2]), .sda_oe(sda_oe), .irq_n_out(lows[1]), .irq_oe(irq_oe),
    .square_wave_out(lows[0]), .square_wave_oe(wave_oe));
  i2c_host_model #(.DEV_ADDR(7'h51)) u_host (
    .mclk(mclk), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ==========
  // Access and compare tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b0, a, d, q, nk);
    chk({7'h0, nk}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.access(1'b1, a, 8'h00, q, nk);
    chk({7'h0, nk}, 8'h00);
    chk(q, e);
  endtask
  task automatic edges(output int n);
    logic p;
    n = 0;
    p = wave_oe;
    repeat (700) begin
      @(negedge mclk);
      n += int'(wave_oe !== p);
      p = wave_oe;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    rd(ADDR_WAVE_CTRL, 8'h80);
    chk({5'h0, lows}, 8'h00);
    rd(ADDR_ALARM_CTRL, 8'h00);
    rd(ADDR_SECONDS, 8'h80);
    for (int i = 0; i < 7; i++) begin
      wr(8'(2 + i), tv[i]);
      rd(8'(2 + i), tv[i]);
    end
    u_host.access(1'b0, 8'h10, 8'h55, q, nk);
    chk({7'h0, nk}, 8'h01);
    rd(ADDR_LAST, 8'h00);
    run = 1'b0;
    repeat (200) @(negedge mclk);
    run = 1'b1;
    rd(ADDR_SECONDS, 8'hb0);
    wr(ADDR_ALARM_MIN, 8'h07);
    wr(ADDR_ALARM_WDAY, 8'h02);
    wr(ADDR_MINUTES, 8'h07);
    rd(ADDR_ALARM_CTRL, 8'h00);
    wr(ADDR_WEEKDAY, 8'h02);
    rd(ADDR_ALARM_CTRL, 8'h08);
    chk({7'h0, irq_oe}, 8'h00);
    wr(ADDR_ALARM_CTRL, 8'h0a);
    chk({7'h0, irq_oe}, 8'h01);
    wr(ADDR_ALARM_CTRL, 8'h02);
    chk({7'h0, irq_oe}, 8'h00);
    wr(ADDR_ALARM_WDAY, 8'h82);
    wr(ADDR_MINUTES, 8'h08);
    wr(ADDR_MINUTES, 8'h07);
    rd(ADDR_ALARM_CTRL, 8'h0a);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_WAVE_CTRL, 8'h80 | 8'(c));
      edges(k);
      chk(8'(k >= lo[c] && k <= hi[c]), 8'h01);
    end
    wr(ADDR_WAVE_CTRL, 8'h00);
    edges(k);
    chk(8'(k) | {7'h0, wave_oe}, 8'h00);
    wrap_up();
  end
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
